// ---- ring_mac_tx.v ----
/*
 Transmit side of the ring MAC: frame check, protocol timers, transmit latch, processor registers.
 Assumes the receive and transmit state machines drive the strobes; all inputs synchronous to i_clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ring_tx_defs.vh"

module ring_mac_tx
(
   // Clock and reset
   input  wire        i_clock,
   input  wire        i_nrst,
   // Processor port
   input  wire        i_proc_sel,
   input  wire        i_proc_wr,
   input  wire [5:0]  i_processor_address_bits,
   input  wire [15:0] i_proc_wdata,
   output reg  [15:0] o_proc_rdata,
   output reg         o_irq,
   // Frame byte bus from send-frame logic
   input  wire [7:0]  i_frame_data,
   input  wire        i_frame_sel,
   input  wire        i_crc_init,
   input  wire        i_crc_strobe,
   input  wire        i_crc_gen,
   input  wire        i_crc_send,
   input  wire        i_crc_check_end,
   // Repeat path
   input  wire [7:0]  i_repeat_pair,
   input  wire        i_status_sym,
   input  wire [2:0]  i_status_index,
   input  wire [3:0]  i_status_force,
   input  wire        i_fragment_last,
   output reg  [7:0]  o_tx_pair,
   // Token and timer control
   input  wire        i_token_capture,
   input  wire        i_good_frame,
   input  wire        i_open_token,
   input  wire        i_tvx_enable,
   input  wire        i_tvx_reset,
   input  wire        i_trt_restart,
   input  wire        i_late_load,
   input  wire        i_late_dec,
   input  wire        i_async_request,
   input  wire        i_claim_info,
   input  wire [7:0]  i_rx_byte,
   output reg         o_async_permit,
   // Scan chain
   input  wire        i_scan_mode,
   input  wire        i_scan_in,
   output reg         o_scan_out,
   // Timer events
   output reg         o_trt_expired,
   output reg         o_tvx_expired,
   output reg         o_tht_expired,
   output reg         o_late_zero
);

   reg  [15:0] rx_control_q;
   reg  [15:0] tx_control_q;
   reg  [15:0] mask_low_q;
   reg  [15:0] mask_mid_q;
   reg  [15:0] mask_high_q;
   reg  [15:0] short_addr_q;
   reg  [15:0] long_low_q;
   reg  [15:0] long_mid_q;
   reg  [15:0] long_high_q;
   reg  [15:0] req_rot_q;
   reg  [15:0] timer_init_q;
   reg  [15:0] event_low_q;
   reg  [15:0] event_mid_q;
   reg  [2:0]  event_high_q;
   reg  [31:0] crc_q;
   reg  [23:0] trt_q;
   reg  [23:0] tht_q;
   reg  [15:0] tvx_q;
   reg  [31:0] bid_time_field_q;
   reg         late_q;
   reg  [3:0]  late_token_counter_q;
   reg  [1:0]  crc_out_idx_q;
   reg  [15:0] scan_q;

   wire        mac_on = rx_control_q[`B_MAC_ON];
   reg  [31:0] crc_d;
   reg  [7:0]  pair_d;
   reg  [15:0] rdata_d;
   reg         known;
   reg         writable;
   integer     k;
   reg         ev_crc;
   reg         ev_perr;
   wire        trt_exp = &trt_q;
   wire        tht_exp = &tht_q;
   wire        tvx_exp = &tvx_q;
   wire        rd_strobe = i_proc_sel & ~i_proc_wr;
   wire        wr_strobe = i_proc_sel & i_proc_wr;

   // Byte-wide CRC, reflected bit order as on the ring
   always @*
   begin
      crc_d = crc_q;
      for (k = 0; k < 8; k = k + 1)
      begin
         if (crc_d[0] ^ i_frame_data[k])
            crc_d = {1'b0, crc_d[31:1]} ^ `CRC_POLY;
         else
            crc_d = {1'b0, crc_d[31:1]};
      end
   end

   // Address decode
   always @*
   begin
      known = 1'b1;
      writable = 1'b0;
      rdata_d = 16'h0000;
      case (i_processor_address_bits)
         `A_RX_CONTROL: begin rdata_d = rx_control_q; writable = 1'b1; end
         `A_TX_CONTROL: begin rdata_d = tx_control_q; writable = 1'b1; end
         `A_MASK_LOW:   begin rdata_d = mask_low_q; writable = 1'b1; end
         `A_MASK_MID:   begin rdata_d = mask_mid_q; writable = 1'b1; end
         `A_MASK_HIGH:  begin rdata_d = mask_high_q; writable = 1'b1; end
         `A_SHORT_ADDR: begin rdata_d = short_addr_q; writable = ~mac_on; end
         `A_LONG_LOW:   begin rdata_d = long_low_q; writable = ~mac_on; end
         `A_LONG_MID:   begin rdata_d = long_mid_q; writable = ~mac_on; end
         `A_LONG_HIGH:  begin rdata_d = long_high_q; writable = ~mac_on; end
         `A_REQ_ROT:    begin rdata_d = req_rot_q; writable = ~mac_on; end
         `A_TIMER_INIT: begin rdata_d = timer_init_q; writable = ~mac_on; end
         `A_REVISION:   rdata_d = {4'h0, `REV_VALUE};
         `A_EVENT_HIGH: rdata_d = {13'h0000, event_high_q};
         `A_EVENT_LOW:  rdata_d = event_low_q;
         `A_EVENT_MID:  rdata_d = event_mid_q;
         `A_TX_STATE:   rdata_d = {13'h0000, o_async_permit, late_token_counter_q == 4'h0, mac_on};
         `A_NEG_LOW:    rdata_d = bid_time_field_q[15:0];
         `A_NEG_HIGH:   rdata_d = {8'h00, bid_time_field_q[23:16]};
         `A_INFO_LOW:   rdata_d = bid_time_field_q[15:0];
         `A_INFO_HIGH:  rdata_d = bid_time_field_q[31:16];
         `A_TVX_VAL:    rdata_d = tvx_q;
         `A_TRT_LOW:    rdata_d = trt_q[15:0];
         `A_TRT_HIGH:   rdata_d = {8'h00, trt_q[23:16]};
         `A_THT_LOW:    rdata_d = tht_q[15:0];
         `A_THT_HIGH:   rdata_d = {8'h00, tht_q[23:16]};
         `A_TXC_LOW:    rdata_d = crc_q[15:0];
         `A_TXC_HIGH:   rdata_d = crc_q[31:16];
         `A_VOID_TIME, `A_TOKEN_COUNTER, `A_FRAME_COUNTER, `A_LOST_ERR, `A_RX_STATE, `A_SIGNATURE, `A_PKT_REQ,
         `A_RXC_LOW, `A_RXC_HIGH: rdata_d = 16'h0000;
         default: known = 1'b0;
      endcase
   end

   always @*
   begin
      ev_crc = i_crc_check_end & ~i_crc_gen & (crc_q != `CRC_RESIDUE);
      ev_perr = i_proc_sel & (~known | (i_proc_wr & ~writable));
   end

   // Transmit latch: repeat or frame data per symbol pair
   always @*
   begin
      pair_d = i_repeat_pair;
      if (i_frame_sel)
      begin
         if (i_crc_send & i_crc_gen)
            pair_d = ~crc_q[8*crc_out_idx_q +: 8];
         else
            pair_d = i_frame_data;
      end
      else if (i_fragment_last)
         pair_d = `IDLE_PAIR;
      else if (i_status_sym)
      begin
         if ((i_status_index == 3'd4 && rx_control_q[`B_SET_BIT5]) ||
             (i_status_index == 3'd3 && rx_control_q[`B_SET_BIT4]))
            pair_d = {`S_SYMBOL, i_repeat_pair[3:0]};
         else
            pair_d = {i_status_force | i_repeat_pair[7:4], i_repeat_pair[3:0]};
      end
   end

   always @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         rx_control_q <= `RESET_16;
         tx_control_q <= `RESET_16;
         mask_low_q <= `RESET_16;
         mask_mid_q <= `RESET_16;
         mask_high_q <= `RESET_16;
         short_addr_q <= `RESET_16;
         long_low_q <= `RESET_16;
         long_mid_q <= `RESET_16;
         long_high_q <= `RESET_16;
         req_rot_q <= `RESET_16;
         timer_init_q <= `RESET_16;
         event_low_q <= `RESET_16;
         event_mid_q <= `RESET_16;
         event_high_q <= 3'h0;
         o_proc_rdata <= `RESET_16;
         o_irq <= 1'b0;
      end
      else
      begin
         if (wr_strobe & known & writable)
         begin
            case (i_processor_address_bits)
               `A_RX_CONTROL: rx_control_q <= i_proc_wdata;
               `A_TX_CONTROL: tx_control_q <= i_proc_wdata;
               `A_MASK_LOW:   mask_low_q <= i_proc_wdata;
               `A_MASK_MID:   mask_mid_q <= i_proc_wdata;
               `A_MASK_HIGH:  mask_high_q <= i_proc_wdata;
               `A_SHORT_ADDR: short_addr_q <= i_proc_wdata;
               `A_LONG_LOW:   long_low_q <= i_proc_wdata;
               `A_LONG_MID:   long_mid_q <= i_proc_wdata;
               `A_LONG_HIGH:  long_high_q <= i_proc_wdata;
               `A_REQ_ROT:    req_rot_q <= i_proc_wdata;
               `A_TIMER_INIT: timer_init_q <= i_proc_wdata;
               default:       rx_control_q <= rx_control_q;
            endcase
         end
         // Clear on read, new events in the same cycle still land
         event_low_q <= ((rd_strobe && i_processor_address_bits == `A_EVENT_LOW) ? 16'h0000 : event_low_q)
                        | {11'h000, o_late_zero & ~late_q, tht_exp & mac_on, trt_exp & mac_on,
                           tvx_exp & mac_on & i_tvx_enable, ev_crc};
         event_mid_q <= ((rd_strobe && i_processor_address_bits == `A_EVENT_MID) ? 16'h0000 : event_mid_q)
                        | {15'h0000, ev_perr};
         event_high_q <= (rd_strobe && i_processor_address_bits == `A_EVENT_HIGH) ? 3'h0 : event_high_q;
         if (rd_strobe)
            o_proc_rdata <= rdata_d;
         o_irq <= |(event_low_q & mask_low_q) | |(event_mid_q & mask_mid_q)
                  | |(event_high_q & mask_high_q[2:0]);
      end
   end

   // Check generator, timers and latch
   always @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         crc_q <= `CRC_INIT;
         crc_out_idx_q <= 2'd0;
         trt_q <= `RESET_24;
         tht_q <= `RESET_24;
         tvx_q <= `RESET_16;
         bid_time_field_q <= 32'h00000000;
         late_token_counter_q <= 4'h0;
         late_q <= 1'b0;
         o_tx_pair <= `IDLE_PAIR;
         o_async_permit <= 1'b0;
         o_trt_expired <= 1'b0;
         o_tvx_expired <= 1'b0;
         o_tht_expired <= 1'b0;
         o_late_zero <= 1'b0;
         o_scan_out <= 1'b0;
         scan_q <= 16'h0000;
      end
      else
      begin
         if (i_crc_init)
         begin
            crc_q <= `CRC_INIT;
            crc_out_idx_q <= 2'd0;
         end
         else if (i_crc_strobe)
            crc_q <= crc_d;
         else if (i_crc_send)
            crc_out_idx_q <= crc_out_idx_q + 2'd1;
         o_tx_pair <= pair_d;
         // Timers count up toward all ones while machines run
         if (mac_on)
         begin
            if (i_trt_restart || trt_exp)
               trt_q <= {8'hff, timer_init_q};
            else
               trt_q <= trt_q + 24'd1;
            if (i_token_capture)
               tht_q <= trt_q;
            else if (!tht_exp)
               tht_q <= tht_q + 24'd1;
            if (i_tvx_reset || i_good_frame || i_open_token || tvx_exp)
               tvx_q <= {8'hff, timer_init_q[15:8]};
            else if (i_tvx_enable)
               tvx_q <= tvx_q + 16'd1;
         end
         if (i_claim_info)
         begin
            bid_time_field_q <= {bid_time_field_q[23:0], i_rx_byte};
         end
         if (i_late_load)
            late_token_counter_q <= 4'h1;
         else if (i_late_dec && late_token_counter_q != 4'h0)
            late_token_counter_q <= late_token_counter_q - 4'h1;
         late_q <= o_late_zero;
         o_async_permit <= i_async_request & mac_on & ~tht_exp;
         o_trt_expired <= mac_on & trt_exp;
         o_tvx_expired <= mac_on & i_tvx_enable & tvx_exp;
         o_tht_expired <= mac_on & tht_exp;
         o_late_zero <= late_token_counter_q == 4'h0;
         // Boundary scan shift of captured pin values
         if (i_scan_mode)
            scan_q <= {scan_q[14:0], i_scan_in};
         else
            scan_q <= {i_frame_data, o_tx_pair};
         o_scan_out <= scan_q[15];
      end
   end

endmodule // ring_mac_tx

`default_nettype wire

// ---- ring_tx_defs.vh ----
/*
 Constants for the ring MAC transmit timers, check generator, latch and register map.
 Assumes a single byte clock at 50 MHz; included by bare name.
*/
// Behaviour
// - Append 32-bit check sequence to each frame when generation is requested.
// - If packet carries its check, verify it and flag a mismatch event.
// - Check failure raises interrupt only when its mask bit leaves it unmasked.
// - Check logic consumes frame byte bus under transmit state machine control.
// - Transmit machine repeats frames, captures tokens, holds, issues token types.
// - No separate operative rotation time register exists.
// - Valid-transmission timer restarts on good frame or open token; expiry flags faults.
// - Rotation timer measures each rotation; used for loss and transmit permission.
// - Rotation timer also times claim and beacon recovery.
// - On capture, holding timer loads from rotation timer.
// - Asynchronous frames allowed only until holding timer expires.
// - Bid time register loads from received claim frame information field.
// - Receive machine enables, disables and resets valid-transmission timer.
// - Timer outputs are only four events: rotation, valid, holding, late zero.
// - Transmit latch picks repeat or frame bytes per symbol pair to physical chip.
// - Repeated status symbols may be altered by status logic and extra settings.
// - Fragment replaces final repeated symbol pair with idle pair.
// - Each chip signal except match, test and clocks has a scan latch; here only i_frame_data and o_tx_pair are captured.
// - Register pairs hold low bits in A and high bits in B.
// - Six-bit processor address selects registers, hex digits from upper and lower bits.
// - Read-and-clear registers clear on read; concurrent update stores new state.
// - Bad reads or writes complete normally, change nothing, set access error event.
// - Timers hold two's complement remaining time in 80 ns octets; here they count up once per 20 ns clock.
`ifndef RING_TX_DEFS_VH
`define RING_TX_DEFS_VH

`define A_RX_CONTROL     6'h00
`define A_TX_CONTROL     6'h01
`define A_MASK_LOW       6'h02
`define A_MASK_MID       6'h03
`define A_MASK_HIGH      6'h04
`define A_SHORT_ADDR     6'h10
`define A_LONG_LOW       6'h11
`define A_LONG_MID       6'h12
`define A_LONG_HIGH      6'h13
`define A_REQ_ROT        6'h14
`define A_TIMER_INIT     6'h15
`define A_REVISION       6'h1c
`define A_EVENT_HIGH     6'h1d
`define A_VOID_TIME      6'h1e
`define A_TOKEN_COUNTER       6'h1f
`define A_FRAME_COUNTER       6'h20
`define A_LOST_ERR       6'h21
`define A_EVENT_LOW      6'h22
`define A_EVENT_MID      6'h23
`define A_RX_STATE       6'h24
`define A_TX_STATE       6'h25
`define A_NEG_LOW        6'h26
`define A_NEG_HIGH       6'h27
`define A_INFO_LOW       6'h28
`define A_INFO_HIGH      6'h29
`define A_SIGNATURE      6'h2a
`define A_TVX_VAL        6'h2b
`define A_TRT_LOW        6'h2c
`define A_TRT_HIGH       6'h2d
`define A_THT_LOW        6'h2e
`define A_THT_HIGH       6'h2f
`define A_PKT_REQ        6'h30
`define A_RXC_LOW        6'h31
`define A_RXC_HIGH       6'h32
`define A_TXC_LOW        6'h33
`define A_TXC_HIGH       6'h34

// Control bit positions (rx_control)
`define B_MAC_ON         15
`define B_SET_BIT5       14
`define B_SET_BIT4       13
// Event bit positions
`define B_EV_TXCRC       0
`define B_EV_TVX         1
`define B_EV_TRT         2
`define B_EV_THT         3
`define B_EV_LATE        4
`define B_EV_PERR        0

`define CRC_POLY         32'hedb88320
`define CRC_INIT         32'hffffffff
`define CRC_RESIDUE      32'hdebb20e3
`define REV_VALUE        12'h0a5
`define IDLE_PAIR        8'h00
`define S_SYMBOL         4'h7
`define OCTET_NS         80
`define CLK_NS           20
`define OCTET_CYCLES     (`OCTET_NS / `CLK_NS)
`define RESET_16         16'h0000
`define RESET_24         24'h000000

`endif

// ---- ring_mac_tx_monitor.sv ----
/*
 Checker for ring_mac_tx: transmit latch, access port, scan chain, late counter.
 Assumes it is bound to ring_mac_tx and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ring_tx_defs.vh"
module ring_mac_tx_check
(
   // Clock and reset
   input wire logic        i_clock,
   input wire logic        i_nrst,
   // Processor port
   input wire logic        i_proc_sel,
   input wire logic        i_proc_wr,
   input wire logic [5:0]  i_processor_address_bits,
   input wire logic [15:0] o_proc_rdata,
   // Transmit latch
   input wire logic [7:0]  i_frame_data,
   input wire logic        i_frame_sel,
   input wire logic        i_crc_send,
   input wire logic [7:0]  i_repeat_pair,
   input wire logic        i_status_sym,
   input wire logic [3:0]  i_status_force,
   input wire logic        i_fragment_last,
   input wire logic [7:0]  o_tx_pair,
   // Timers and scan
   input wire logic        i_late_load,
   input wire logic        i_late_dec,
   input wire logic        o_late_zero,
   input wire logic        i_async_request,
   input wire logic        o_async_permit,
   input wire logic        i_scan_mode,
   input wire logic        i_scan_in,
   input wire logic        o_scan_out
);
   logic [4:0] scan_run_q;

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_nrst);

   // Consecutive shift cycles, saturating
   always @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         scan_run_q <= 5'h00;
      else if (!i_scan_mode)
         scan_run_q <= 5'h00;
      else if (scan_run_q != 5'h1f)
         scan_run_q <= scan_run_q + 5'h01;
   end

   sequence repeat_slot_s;
      !i_frame_sel && !i_crc_send && !i_scan_mode && !i_fragment_last;
   endsequence
   sequence rev_read_s;
      i_proc_sel && !i_proc_wr && i_processor_address_bits == `A_REVISION;
   endsequence

   fragment_idle_a: assert property (!i_frame_sel && !i_scan_mode && i_fragment_last |=> o_tx_pair == `IDLE_PAIR)
      else $error("fragment end not replaced by idle pair");
   repeat_copy_a: assert property (repeat_slot_s ##0 !i_status_sym |=> o_tx_pair == $past(i_repeat_pair))
      else $error("repeat pair not forwarded");
   status_force_a: assert property (repeat_slot_s ##0 i_status_sym |=>
      o_tx_pair == ($past(i_repeat_pair) | {$past(i_status_force), 4'h0}))
      else $error("status symbol not altered as set");
   frame_copy_a: assert property (i_frame_sel && !i_crc_send && !i_scan_mode && !i_fragment_last |=>
      o_tx_pair == $past(i_frame_data))
      else $error("frame byte not forwarded");
   permit_request_a: assert property (o_async_permit |-> $past(i_async_request))
      else $error("permit without request");
   late_reload_a: assert property (i_late_load && !i_late_dec |-> ##[1:2] !o_late_zero)
      else $error("late counter zero after load");
   scan_shift_a: assert property (scan_run_q > 5'h11 |->
      o_scan_out == $past(i_scan_in, 16) || o_scan_out == $past(i_scan_in, 17))
      else $error("scan chain length wrong");
   revision_read_a: assert property (rev_read_s |=> o_proc_rdata == {4'h0, `REV_VALUE})
      else $error("revision read wrong");
   rdata_hold_a: assert property (!(i_proc_sel && !i_proc_wr) |=> $stable(o_proc_rdata))
      else $error("read data moved without a read");
endmodule // ring_mac_tx_check

bind ring_mac_tx ring_mac_tx_check u_check
(
   .i_clock, .i_nrst, .i_proc_sel, .i_proc_wr, .i_processor_address_bits, .o_proc_rdata,
   .i_frame_data, .i_frame_sel, .i_crc_send, .i_repeat_pair, .i_status_sym, .i_status_force,
   .i_fragment_last, .o_tx_pair, .i_late_load, .i_late_dec, .o_late_zero, .i_async_request,
   .o_async_permit, .i_scan_mode, .i_scan_in, .o_scan_out
);
`default_nettype wire

// ---- repeat_symbol_source.sv ----
/*
 Receive-path model that feeds repeat symbol pairs to the transmit latch.
 Assumes the bench byte clock and reset; a new pair every clock.
*/
`timescale 1ns/10ps
`default_nettype none
module repeat_symbol_source
(
   // Clock and reset
   input  wire logic      i_clock,
   input  wire logic      i_nrst,
   // Repeat path
   output var logic [7:0] o_pair
);
   // Maximal-length shift pattern, never holds a value
   always @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         o_pair <= 8'h01;
      else
         o_pair <= {o_pair[6:0], o_pair[7] ^ o_pair[5] ^ o_pair[4] ^ o_pair[3]};
   end
endmodule // repeat_symbol_source
`default_nettype wire

// ---- test_ring_mac_tx_timers_and_regmap.sv ----
/*
 Self-checking bench for ring_mac_tx: registers, frame check, timers, latch traffic.
 Assumes the checker bind and repeat_symbol_source are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ring_tx_defs.vh"
module test_ring_mac_tx_timers_and_regmap;
   logic        i_clock = 1'b0;
   logic        i_nrst = 1'b0;
   logic        i_proc_sel, i_proc_wr, i_frame_sel, i_crc_init, i_crc_strobe, i_crc_gen, i_crc_send;
   logic        i_crc_check_end, i_status_sym, i_fragment_last, i_token_capture, i_good_frame;
   logic        i_open_token, i_tvx_enable, i_tvx_reset, i_trt_restart, i_late_load, i_late_dec;
   logic        i_async_request, i_claim_info, i_scan_mode, i_scan_in, rd_pend_q = 1'b0;
   logic        o_irq, o_async_permit, o_scan_out, o_trt_expired, o_tvx_expired, o_tht_expired, o_late_zero;
   logic [5:0]  i_processor_address_bits;
   logic [15:0] i_proc_wdata, o_proc_rdata, v, cw[6];
   logic [7:0]  i_frame_data, i_rx_byte, i_repeat_pair, o_tx_pair, fr[12];
   logic [2:0]  i_status_index;
   logic [3:0]  i_status_force;
   logic [31:0] exp_q[$], note, r;
   int          fail_count = 0, num_checks = 0, n;

   ring_mac_tx dut (.i_clock, .i_nrst, .i_proc_sel, .i_proc_wr, .i_processor_address_bits, .i_proc_wdata,
      .o_proc_rdata, .o_irq, .i_frame_data, .i_frame_sel, .i_crc_init, .i_crc_strobe, .i_crc_gen, .i_crc_send,
      .i_crc_check_end, .i_repeat_pair, .i_status_sym, .i_status_index, .i_status_force, .i_fragment_last,
      .o_tx_pair, .i_token_capture, .i_good_frame, .i_open_token, .i_tvx_enable, .i_tvx_reset, .i_trt_restart,
      .i_late_load, .i_late_dec, .i_async_request, .i_claim_info, .i_rx_byte, .o_async_permit, .i_scan_mode,
      .i_scan_in, .o_scan_out, .o_trt_expired, .o_tvx_expired, .o_tht_expired, .o_late_zero);
   repeat_symbol_source u_source (.i_clock, .i_nrst, .o_pair(i_repeat_pair));

   always #10 i_clock = ~i_clock;

   task automatic tick(input int k = 1);
      repeat (k) @(posedge i_clock);
      #2;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] want);
      num_checks++;
      if (got !== want)
      begin
         fail_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, want);
      end
   endtask

   task automatic give_verdict;
      $display("Checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // One access and one idle cycle; for a read d is the expected value under mask m
   task automatic acc(input logic w, input logic [5:0] a, input logic [15:0] d, input logic [15:0] m = 16'hffff);
      if (!w)
         exp_q.push_back({m, d});
      i_proc_sel = 1'b1;
      i_proc_wr = w;
      i_processor_address_bits = a;
      i_proc_wdata = d;
      tick();
      i_proc_sel = 1'b0;
      tick();
   endtask

   task automatic crc_frame(input logic gen, input logic [7:0] flip);
      i_crc_gen = gen;
      i_frame_sel = 1'b1;
      i_crc_init = 1'b1;
      tick();
      i_crc_init = 1'b0;
      i_crc_strobe = 1'b1;
      for (int k = 0; k < (gen ? 8 : 12); k++)
      begin
         i_frame_data = fr[k] ^ ((k == 3) ? flip : 8'h00);
         tick();
      end
      i_crc_strobe = 1'b0;
      i_crc_send = gen;
      i_crc_check_end = !gen;
      for (int k = 8; k < (gen ? 12 : 9); k++)
      begin
         tick();
         if (gen)
            fr[k] = o_tx_pair;
      end
      {i_crc_send, i_crc_check_end, i_frame_sel} = 3'h0;
      tick();
   endtask

   // Compares each read result with the oldest note
   always @(posedge i_clock)
   begin
      if (rd_pend_q)
      begin
         note = exp_q.pop_front();
         check(o_proc_rdata & note[31:16], note[15:0] & note[31:16]);
      end
      rd_pend_q <= i_proc_sel && !i_proc_wr && i_nrst;
   end

   initial
   begin
      #100000;
      fail_count++;
      give_verdict();
   end

   initial
   begin
      {i_proc_sel, i_proc_wr, i_frame_sel, i_crc_init, i_crc_strobe, i_crc_gen, i_crc_send, i_crc_check_end} = 8'h00;
      {i_status_sym, i_fragment_last, i_token_capture, i_good_frame, i_open_token, i_tvx_enable} = 6'h00;
      {i_tvx_reset, i_trt_restart, i_late_load, i_late_dec, i_async_request, i_claim_info} = 6'h00;
      {i_scan_mode, i_scan_in, i_processor_address_bits, i_proc_wdata, i_frame_data, i_rx_byte} = 40'h0;
      {i_status_index, i_status_force} = 7'h00;
      r = $urandom(32'h0446f075);
      for (int k = 0; k < 8; k++)
         fr[k] = 8'($urandom);
      tick(3);
      i_nrst = 1'b1;
      tick();
      for (int a = 0; a < 5; a++)
         acc(1'b0, a[5:0], 16'h0000);
      acc(1'b0, `A_REVISION, {4'h0, `REV_VALUE});
      acc(1'b0, `A_EVENT_MID, 16'h0000);
      for (int a = 0; a < 5; a++)
      begin
         v = 16'((a == 0) ? ($urandom & 16'h1ff8) : $urandom);
         acc(1'b1, a[5:0], v);
         acc(1'b0, a[5:0], v);
         acc(1'b1, a[5:0], 16'h0000);
      end
      for (int a = 0; a < 6; a++)
      begin
         cw[a] = (a == 5) ? 16'hfff0 : 16'($urandom);
         acc(1'b1, 6'h10 + a[5:0], cw[a]);
         acc(1'b0, 6'h10 + a[5:0], cw[a]);
      end
      {i_trt_restart, i_tvx_reset} = 2'h3;
      acc(1'b1, `A_RX_CONTROL, 16'h8000);
      i_token_capture = 1'b1;
      acc(1'b1, `A_RX_CONTROL, 16'h0000);
      {i_trt_restart, i_tvx_reset, i_token_capture} = 3'h0;
      tick(20);
      acc(1'b0, `A_TRT_LOW, 16'hfff0);
      acc(1'b0, `A_TRT_HIGH, 16'h00ff);
      acc(1'b0, `A_TVX_VAL, 16'hffff);
      acc(1'b0, `A_THT_LOW, 16'hfff0);
      {i_async_request, i_tvx_enable} = 2'h3;
      acc(1'b1, `A_RX_CONTROL, 16'h8000);
      check({15'h0, o_async_permit}, 16'h0001);
      n = 0;
      while (o_trt_expired !== 1'b1 && n < 40)
      begin
         tick();
         n++;
      end
      check({15'h0, n >= 10 && n <= 18}, 16'h0001);
      check({15'h0, o_tht_expired}, 16'h0001);
      check({15'h0, o_tvx_expired}, 16'h0001);
      tick();
      check({15'h0, o_async_permit}, 16'h0000);
      acc(1'b1, `A_SHORT_ADDR, ~cw[0]);
      acc(1'b0, `A_EVENT_MID, 16'h0001);
      acc(1'b0, `A_EVENT_MID, 16'h0000);
      acc(1'b0, 6'h3f, 16'h0000, 16'h0000);
      acc(1'b0, `A_EVENT_MID, 16'h0001);
      acc(1'b1, `A_REVISION, 16'hffff);
      acc(1'b0, `A_REVISION, {4'h0, `REV_VALUE});
      acc(1'b0, `A_EVENT_MID, 16'h0001);
      acc(1'b0, `A_SHORT_ADDR, cw[0]);
      for (int k = 0; k < 200; k++)
      begin
         r = $urandom;
         {i_frame_sel, i_status_sym, i_status_index, i_late_dec, i_async_request} = r[6:0];
         {i_frame_data, i_status_force, i_good_frame, i_open_token, i_tvx_enable} = r[22:8];
         i_fragment_last = &r[25:23];
         i_late_load = &r[27:26];
         i_token_capture = &r[29:28];
         tick();
      end
      {i_frame_sel, i_status_sym, i_fragment_last, i_late_load, i_late_dec, i_token_capture} = 6'h00;
      acc(1'b1, `A_RX_CONTROL, 16'h0000);
      i_claim_info = 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         i_rx_byte = fr[k];
         tick();
      end
      i_claim_info = 1'b0;
      acc(1'b0, `A_INFO_LOW, {fr[2], fr[3]});
      acc(1'b0, `A_INFO_HIGH, {fr[0], fr[1]});
      crc_frame(1'b1, 8'h00);
      acc(1'b0, `A_EVENT_LOW, 16'h0000, 16'h0000);
      crc_frame(1'b0, 8'h00);
      acc(1'b0, `A_EVENT_LOW, 16'h0000, 16'h0001);
      crc_frame(1'b0, 8'h10);
      tick(2);
      check({15'h0, o_irq}, 16'h0000);
      acc(1'b1, `A_MASK_LOW, 16'h0001);
      check({15'h0, o_irq}, 16'h0001);
      acc(1'b0, `A_EVENT_LOW, 16'h0001, 16'h0001);
      tick();
      check({15'h0, o_irq}, 16'h0000);
      i_scan_mode = 1'b1;
      repeat (40)
      begin
         r = $urandom;
         i_scan_in = r[0];
         tick();
      end
      i_scan_mode = 1'b0;
      tick(2);
      give_verdict();
   end
endmodule // test_ring_mac_tx_timers_and_regmap
`default_nettype wire
